// ==== pkg/rpc_pkg.sv ====
// package for the reset / power-down pin control block
package rpc_pkg;

  // host interface choice from the two select lines
  typedef enum logic [1:0] {
    RPC_IF_SEL0 = 2'b00,
    RPC_IF_SEL1 = 2'b01,
    RPC_IF_SEL2 = 2'b10,
    RPC_IF_SEL3 = 2'b11
  } rpc_host_if_e;

  // sequencer states
  typedef enum logic [1:0] {
    RPC_ST_PD    = 2'b00,
    RPC_ST_RESET = 2'b01,
    RPC_ST_RUN   = 2'b10,
    RPC_ST_HOLD  = 2'b11
  } rpc_state_e;

  // internal reset phase length, in ns, and in cycles at 200 MHz
  localparam int unsigned RPC_CLK_PERIOD_PS  = 5000;
  localparam int unsigned RPC_RESET_PHASE_NS = 1000;
  localparam int unsigned RPC_RESET_CYCLES   = (RPC_RESET_PHASE_NS * 1000 + RPC_CLK_PERIOD_PS - 1) / RPC_CLK_PERIOD_PS;
  localparam int unsigned RPC_CNT_W          = 8;

  // irq level follows this bit of the port 7 output latch
  localparam int unsigned RPC_IRQ_BIT = 0;

  // reset values
  localparam logic [1:0] RPC_IF_RST = 2'h0;

  // pad controls of one general-purpose pin
  typedef struct packed {
    logic dout;
    logic oe_n;
  } rpc_pad_s;

endpackage

// ==== rtl/rpc_reset_ctrl.sv ====
// reset, power-down, test-enable and host signalling pin control
`timescale 1ns/1ps

// Overview of operation
// - reset input high: sources off, oscillator stopped, pads isolated
// - falling reset input edge starts internal reset phase
// - reset-state output low while in reset
// - test enable low holds test block reset
// - hold pin floats host outputs, powers down, keeps state
// - irq output follows port 7 latch bit 0
// - external interrupt pin: plain io or interrupt
// - two pins: plain io (tx pin output only, its gpio input reads 0) or aux serial tx/rx
// - select lines choose host interface, test signals in test
module rpc_reset_ctrl
  import rpc_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RPC_RESET_CYCLES
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // pins from the host
  input  wire logic         i_reset_powerdown_in,
  input  wire logic         i_test_enable_in,
  input  wire logic         i_host_if_select_0,
  input  wire logic         i_host_if_select_1,
  input  wire logic         i_hold_powerdown_pin,
  input  wire logic         i_ext_interrupt_pin,
  input  wire logic         i_aux_serial_rx_pin,
  // from the controller core
  input  wire logic [7:0]   i_port7_latch,
  input  wire logic         i_ext_int_mode,
  input  wire logic         i_aux_serial_mode,
  input  wire rpc_pad_s     i_ext_int_gpio,
  input  wire rpc_pad_s     i_tx_gpio,
  input  wire rpc_pad_s     i_rx_gpio,
  input  wire logic         i_aux_serial_tx,
  input  wire logic         i_host_out_oe_n,
  // pin outputs
  output logic              o_reset_state_out_n,
  output logic              o_irq,
  output rpc_pad_s          o_ext_interrupt_pad,
  output rpc_pad_s          o_aux_serial_tx_pad,
  output rpc_pad_s          o_aux_serial_rx_pad,
  output logic              o_host_out_oe_n,
  // to the rest of the device
  output logic              o_current_src_en,
  output logic              o_osc_en,
  output logic              o_pads_connected,
  output logic              o_core_rst,
  output logic              o_test_ctrl_rst,
  output logic              o_test_mode,
  output logic [1:0]        o_host_if,
  output logic              o_powerdown,
  output logic              o_ext_int_req,
  output logic              o_aux_serial_rx,
  output logic [1:0]        o_test_sig,
  output logic              o_gpio_ext_int_in,
  output logic              o_gpio_tx_in,
  output logic              o_gpio_rx_in
);

  // two-stage synchronisers for all pin inputs
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] nxt_sync1;
  logic [NSYNC-1:0] nxt_sync2;

  always_comb begin
    nxt_sync1 = {i_reset_powerdown_in, i_test_enable_in, i_host_if_select_1, i_host_if_select_0,
                 i_hold_powerdown_pin, i_ext_interrupt_pin, i_aux_serial_rx_pin};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // reset input idles as power-down, so a pin held high gives no false release edge
      sync1_ff <= {1'b1, {(NSYNC-1){1'b0}}};
      sync2_ff <= {1'b1, {(NSYNC-1){1'b0}}};
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic reset_powerdown_in_s, test_enable_in_s, hold_s, extint_s, rx_s;
  logic [1:0] sel_s;
  assign {reset_powerdown_in_s, test_enable_in_s, sel_s, hold_s, extint_s, rx_s} = sync2_ff;

  // sequencer
  rpc_state_e               state_ff, nxt_state;
  logic [RPC_CNT_W-1:0]     cnt_ff, nxt_cnt;
  logic                     reset_powerdown_in_d_ff, nxt_reset_powerdown_in_d;
  logic [1:0]               host_if_ff, nxt_host_if;
  logic                     test_ff, nxt_test;

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_reset_powerdown_in_d = reset_powerdown_in_s;
    nxt_host_if = host_if_ff;
    nxt_test    = test_enable_in_s;
    unique case (state_ff)
      RPC_ST_PD: begin
        if (!reset_powerdown_in_s && reset_powerdown_in_d_ff) begin
          nxt_state = RPC_ST_RESET;
          nxt_cnt   = '0;
        end
      end
      RPC_ST_RESET: begin
        if (cnt_ff == RPC_CNT_W'(RESET_CYCLES - 1)) begin
          nxt_state   = RPC_ST_RUN;
          nxt_host_if = sel_s;
        end else begin
          nxt_cnt = cnt_ff + RPC_CNT_W'(1);
        end
      end
      RPC_ST_RUN: begin
        if (hold_s) begin
          nxt_state = RPC_ST_HOLD;
        end
      end
      RPC_ST_HOLD: begin
        if (!hold_s) begin
          nxt_state = RPC_ST_RUN;                                      // state kept
        end
      end
    endcase
    // rising edge or level high forces power-down; reset phase follows
    if (reset_powerdown_in_s) begin
      nxt_state = RPC_ST_PD;
      nxt_cnt   = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff   <= RPC_ST_PD;
      cnt_ff     <= '0;
      reset_powerdown_in_d_ff <= 1'b1;
      host_if_ff <= RPC_IF_RST;
      test_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      reset_powerdown_in_d_ff <= nxt_reset_powerdown_in_d;
      host_if_ff <= nxt_host_if;
      test_ff    <= nxt_test;
    end
  end

  // registered outputs
  logic in_pd, in_rst, in_hold, run_like;
  assign in_pd    = (nxt_state == RPC_ST_PD);
  assign in_rst   = (nxt_state == RPC_ST_PD) || (nxt_state == RPC_ST_RESET);
  assign in_hold  = (nxt_state == RPC_ST_HOLD);
  assign run_like = !in_rst;

  rpc_pad_s nxt_ext_pad, nxt_tx_pad, nxt_rx_pad;
  always_comb begin
    nxt_ext_pad = i_ext_int_gpio;
    nxt_tx_pad  = i_aux_serial_mode ? rpc_pad_s'{dout: i_aux_serial_tx, oe_n: 1'b0} : i_tx_gpio;
    nxt_rx_pad  = i_aux_serial_mode ? rpc_pad_s'{dout: 1'b0, oe_n: 1'b1} : i_rx_gpio;
    if (i_ext_int_mode) begin
      nxt_ext_pad = '{dout: 1'b0, oe_n: 1'b1};                         // input only
    end
    // pads released in the PD and RESET states so nothing fights the pins
    if (in_rst) begin
      nxt_ext_pad = '{dout: 1'b0, oe_n: 1'b1};
      nxt_tx_pad  = '{dout: 1'b0, oe_n: 1'b1};
      nxt_rx_pad  = '{dout: 1'b0, oe_n: 1'b1};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reset_state_out_n <= 1'b0;
      o_irq               <= 1'b0;
      o_ext_interrupt_pad <= '{dout: 1'b0, oe_n: 1'b1};
      o_aux_serial_tx_pad <= '{dout: 1'b0, oe_n: 1'b1};
      o_aux_serial_rx_pad <= '{dout: 1'b0, oe_n: 1'b1};
      o_host_out_oe_n     <= 1'b1;
      o_current_src_en    <= 1'b0;
      o_osc_en            <= 1'b0;
      o_pads_connected    <= 1'b0;
      o_core_rst          <= 1'b1;
      o_test_ctrl_rst     <= 1'b1;
      o_test_mode         <= 1'b0;
      o_host_if           <= RPC_IF_RST;
      o_powerdown         <= 1'b1;
      o_ext_int_req       <= 1'b0;
      o_aux_serial_rx     <= 1'b1;
      o_test_sig          <= 2'h0;
      o_gpio_ext_int_in   <= 1'b0;
      o_gpio_tx_in        <= 1'b0;
      o_gpio_rx_in        <= 1'b0;
    end else begin
      o_reset_state_out_n <= run_like;
      o_irq               <= run_like & i_port7_latch[RPC_IRQ_BIT];
      o_ext_interrupt_pad <= nxt_ext_pad;
      o_aux_serial_tx_pad <= nxt_tx_pad;
      o_aux_serial_rx_pad <= nxt_rx_pad;
      o_host_out_oe_n     <= in_rst | in_hold | i_host_out_oe_n;
      o_current_src_en    <= !in_pd;
      o_osc_en            <= !in_pd;
      o_pads_connected    <= !in_pd;
      o_core_rst          <= in_rst;
      o_test_ctrl_rst     <= !nxt_test;
      o_test_mode         <= nxt_test & run_like;
      o_host_if           <= nxt_host_if;
      o_powerdown         <= in_pd | in_hold;
      o_ext_int_req       <= i_ext_int_mode & !in_pd & extint_s;
      o_aux_serial_rx     <= (i_aux_serial_mode & !in_pd) ? rx_s : 1'b1;
      o_test_sig          <= nxt_test ? sel_s : 2'h0;
      o_gpio_ext_int_in   <= !in_pd & extint_s;
      o_gpio_tx_in        <= 1'b0;
      o_gpio_rx_in        <= !in_pd & !i_aux_serial_mode & rx_s;
    end
  end

endmodule

// ==== tb/rpc_monitor.sv ====
// port checker for the reset and power-down pin control
`timescale 1ns/1ps
module rpc_monitor #(
  parameter int unsigned RESET_CYCLES = 4
) (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // inputs
  input wire logic       i_reset_powerdown_in,
  input wire logic       i_test_enable_in,
  input wire logic       i_hold_powerdown_pin,
  input wire logic       i_ext_interrupt_pin,
  input wire logic       i_ext_int_mode,
  input wire logic [7:0] i_port7_latch,
  // outputs
  input wire logic       o_reset_state_out_n,
  input wire logic       o_irq,
  input wire logic       o_host_out_oe_n,
  input wire logic       o_current_src_en,
  input wire logic       o_osc_en,
  input wire logic       o_core_rst,
  input wire logic       o_test_ctrl_rst,
  input wire logic       o_test_mode,
  input wire logic [1:0] o_host_if,
  input wire logic       o_powerdown,
  input wire logic       o_ext_int_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // cycles of reset phase with the oscillator up; the pin sync makes the start fuzzy
  logic [7:0] n_ff;
  logic [7:0] nxt_n;
  always_comb nxt_n = (o_core_rst && o_osc_en) ? n_ff + 8'h1 : 8'h0;
  always_ff @(posedge i_clk) n_ff <= i_rst ? 8'h0 : nxt_n;
  sequence s_pd_held;
    i_reset_powerdown_in[*5];
  endsequence
  a_pd_all_off: assert property (s_pd_held |-> !o_osc_en && !o_current_src_en)
    else $error("source on in power-down");
  a_phase_len: assert property ($fell(o_core_rst) |-> n_ff + 2 >= RESET_CYCLES && n_ff <= RESET_CYCLES + 1)
    else $error("reset phase length");
  a_rst_out_low: assert property (o_core_rst |-> !o_reset_state_out_n) else $error("status high in reset");
  a_test_held: assert property ((!i_test_enable_in)[*5] |-> o_test_ctrl_rst && !o_test_mode)
    else $error("test block free");
  a_hold_floats: assert property ((i_hold_powerdown_pin && !o_core_rst)[*5] |-> o_host_out_oe_n && o_powerdown)
    else $error("hold not floating");
  a_irq_follows: assert property ((!o_core_rst && !o_powerdown && $stable(i_port7_latch))[*3]
    |-> o_irq == i_port7_latch[0]) else $error("irq level");
  a_ext_int_req: assert property ((i_ext_int_mode && $stable(i_ext_interrupt_pin) && o_osc_en)[*5]
    |-> o_ext_int_req == i_ext_interrupt_pin) else $error("ext request");
  a_if_kept: assert property (!o_core_rst && !$fell(o_core_rst) |-> $stable(o_host_if)) else $error("host if moved");
endmodule

bind rpc_reset_ctrl rpc_monitor #(.RESET_CYCLES(RESET_CYCLES)) u_mon (.*);

// ==== tb/rpc_host_model.sv ====
// host model driving the power-down and interface-select pins
`timescale 1ns/1ps
module rpc_host_model (
  // pins to the device
  output logic o_reset_powerdown_in,
  output logic o_sel0,
  output logic o_sel1
);
  // device starts powered down
  initial {o_reset_powerdown_in, o_sel1, o_sel0} = 3'b100;
  // selects move with the pin so they are settled before the phase ends
  task automatic drive(input logic rst, input logic [1:0] sel);
    o_reset_powerdown_in = rst;
    {o_sel1, o_sel0} = sel;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the reset and power-down pin control
`timescale 1ns/1ps
module tb_top;
  import rpc_pkg::*;
  logic       i_clk, i_rst, i_reset_powerdown_in, i_test_enable_in, i_host_if_select_0, i_host_if_select_1;
  logic       i_hold_powerdown_pin, i_ext_interrupt_pin, i_aux_serial_rx_pin, i_ext_int_mode, i_aux_serial_mode;
  logic       i_aux_serial_tx, i_host_out_oe_n, o_reset_state_out_n, o_irq, o_host_out_oe_n, o_current_src_en;
  logic       o_osc_en, o_pads_connected, o_core_rst, o_test_ctrl_rst, o_test_mode, o_powerdown, o_ext_int_req;
  logic       o_aux_serial_rx, o_gpio_ext_int_in, o_gpio_tx_in, o_gpio_rx_in;
  logic [7:0] i_port7_latch;
  logic [1:0] o_host_if, o_test_sig;
  rpc_pad_s   i_ext_int_gpio, i_tx_gpio, i_rx_gpio, o_ext_interrupt_pad, o_aux_serial_tx_pad, o_aux_serial_rx_pad;
  int         fail_count, compares, cyc, seed;
  int         exp_q[$];

  rpc_reset_ctrl #(.RESET_CYCLES(4)) dut (.*);
  rpc_host_model u_host (.o_reset_powerdown_in(i_reset_powerdown_in), .o_sel0(i_host_if_select_0), .o_sel1(i_host_if_select_1));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rnd();
    {i_port7_latch, i_ext_int_mode, i_ext_interrupt_pin, i_aux_serial_mode, i_aux_serial_tx, i_aux_serial_rx_pin,
     i_host_out_oe_n, i_ext_int_gpio, i_tx_gpio, i_rx_gpio} = 20'($random(seed));
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    seed = 32'h22a44335;
    {i_rst, i_test_enable_in, i_hold_powerdown_pin} = 3'b110;
    rnd();
    step(16);
    i_rst = 1'b0;
    step(6);
    chk({o_current_src_en, o_osc_en, o_pads_connected, o_reset_state_out_n}, 8'h0);
    // pin held high from power-up first, then pulses of 5, 8 and 11 cycles; selects moved after release must not stick
    for (int s = 0; s < 4; s++) begin
      exp_q.push_back(s);
      u_host.drive(1'b1, 2'(s));
      step(2 + 3 * s);
      u_host.drive(1'b0, 2'(s));
      for (int k = 0; k < 40 && o_reset_state_out_n !== 1'b1; k++) step(1);
      chk(o_core_rst, 8'h0);
      u_host.drive(1'b0, ~2'(s));
      step(8);
      chk(o_host_if, 8'(exp_q.pop_front()));
    end
    for (int k = 0; k < 16; k++) begin
      rnd();
      step(5);
      chk(o_irq, i_port7_latch[0]);
      chk(o_ext_int_req, i_ext_int_mode & i_ext_interrupt_pin);
      chk(o_aux_serial_tx_pad, i_aux_serial_mode ? {i_aux_serial_tx, 1'b0} : 2'(i_tx_gpio));
      chk(o_host_out_oe_n, i_host_out_oe_n);
      chk(o_ext_interrupt_pad, i_ext_int_mode ? 8'h1 : 8'(i_ext_int_gpio));
      chk(o_gpio_ext_int_in, i_ext_interrupt_pin);
      chk(o_aux_serial_rx_pad, i_aux_serial_mode ? 8'h1 : 8'(i_rx_gpio));
      chk(o_aux_serial_rx, i_aux_serial_mode ? i_aux_serial_rx_pin : 1'b1);
      chk({o_gpio_rx_in, o_gpio_tx_in}, {~i_aux_serial_mode & i_aux_serial_rx_pin, 1'b0});
    end
    i_hold_powerdown_pin = 1'b1;
    step(6);
    chk({o_host_out_oe_n, o_powerdown, o_host_if}, 8'hf);
    i_hold_powerdown_pin = 1'b0;
    step(6);
    chk({o_powerdown, o_core_rst, o_host_if}, 8'h3);
    i_test_enable_in = 1'b0;
    step(6);
    chk({o_test_ctrl_rst, o_test_mode}, 8'h2);
    i_test_enable_in = 1'b1;
    u_host.drive(1'b0, 2'h2);
    step(6);
    chk({o_test_ctrl_rst, o_test_mode, o_test_sig}, 8'h6);
    chk(o_host_if, 8'h3);
    u_host.drive(1'b1, 2'h0);
    step(6);
    chk({o_current_src_en, o_osc_en, o_pads_connected, o_reset_state_out_n}, 8'h0);
    stop_test();
  end
endmodule
